// *** acsr_regs.vh ***
// Register offsets, field positions and reset values of the control and status slice.
`ifndef ACSR_REGS_VH
`define ACSR_REGS_VH
`define ACSR_ADDR_CAL_BAND      8'h04
`define ACSR_ADDR_FLAG_EN       8'h05
`define ACSR_ADDR_RST_STAT      8'h09
`define ACSR_RST_CAL_BAND       8'h00
`define ACSR_RST_FLAG_EN        8'h01
`define ACSR_RST_RST_STAT       8'h00
`define ACSR_BIT_TX_CAL         0
`define ACSR_BIT_RX_CAL         1
`define ACSR_BIT_TX_GAIN_CAL    2
`define ACSR_BIT_FILTER_BAND    3
`define ACSR_BIT_RX_READY       7
`define ACSR_BIT_THERM_EN       5
`define ACSR_BIT_CURR_EN        6
`define ACSR_SOFT_LSB           2
`define ACSR_SOFT_MSB           4
`define ACSR_SOFT_CODE          3'h5
`define ACSR_BIT_THERM_FLAG     5
`define ACSR_BIT_CURR_FLAG      6
`define ACSR_CMD_WRITE          1'b0
`endif

// *** acsr_serial_frame.v ***
// Four-wire serial frame engine: 16-bit frame, command byte then data byte.
`include "acsr_regs.vh"
`timescale 1ns/1ps
module acsr_serial_frame
(
   clock,
   rst,
   cs_n,
   sdi,
   rd_data,
   sdo,
   wr_stb,
   addr,
   wr_data
);
   input             clock;
   input             rst;
   input             cs_n;
   input             sdi;
   input       [7:0] rd_data;
   output reg        sdo;
   output reg        wr_stb;
   output reg  [7:0] addr;
   output reg  [7:0] wr_data;

   reg  [3:0] cnt_q;
   reg  [7:0] sh_q;
   reg  [7:0] out_q;
   reg        wr_q;

   // Command byte: bit 7 is read (1) or write (0), bits 6..0 the address.
   always @(posedge clock)
   begin
      wr_stb <= 1'b0;
      if (rst || cs_n)
      begin
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         out_q   <= 8'h00;
         wr_q    <= 1'b0;
         sdo     <= 1'b0;
         if (rst)
         begin
            addr    <= 8'h00;
            wr_data <= 8'h00;
         end
      end
      else
      begin
         cnt_q <= cnt_q + 4'h1;
         sh_q  <= {sh_q[6:0], sdi};
         if (cnt_q == 4'h7)
         begin
            addr  <= {1'b0, sh_q[5:0], sdi};
            wr_q  <= (sh_q[6] == `ACSR_CMD_WRITE);
         end
         if (cnt_q == 4'h8)
         begin
            out_q <= {rd_data[6:0], 1'b0};
            sdo   <= rd_data[7];
         end
         else
         begin
            out_q <= {out_q[6:0], 1'b0};
            sdo   <= out_q[7];
         end
         if (cnt_q == 4'hf && wr_q)
         begin
            wr_data <= {sh_q[6:0], sdi};
            wr_stb  <= 1'b1;
         end
      end
   end
endmodule // acsr_serial_frame

// *** acsr_top.v ***
// Control and status registers of the line front end behind the serial port.
`include "acsr_regs.vh"
`timescale 1ns/1ps
module acsr_top
(
   clock,
   rst,
   cs_n,
   sdi,
   sdo,
   reg_select,
   rx_ready,
   therm_overload,
   curr_overload,
   tx_calibration,
   rx_calibration,
   transmit_gain_amp_calibration,
   filter_band_select,
   therm_flag_enable,
   curr_flag_enable,
   therm_flag,
   curr_flag,
   soft_reset_pulse
);
   input      clock;
   input      rst;
   input      cs_n;
   input      sdi;
   output     sdo;
   input      reg_select;
   input      rx_ready;
   input      therm_overload;
   input      curr_overload;
   output     tx_calibration;
   output     rx_calibration;
   output     transmit_gain_amp_calibration;
   output     filter_band_select;
   output     therm_flag_enable;
   output     curr_flag_enable;
   output     therm_flag;
   output     curr_flag;
   output reg soft_reset_pulse;

   localparam [7:0] CAL_BAND_RST = `ACSR_RST_CAL_BAND;
   localparam [7:0] FLAG_EN_RST  = `ACSR_RST_FLAG_EN;
   localparam [7:0] RST_STAT_RST = `ACSR_RST_RST_STAT;

   wire       wr_stb;
   wire [7:0] addr;
   wire [7:0] wr_data;
   reg  [7:0] rd_data;
   reg  [3:0] cal_band_q;
   reg  [3:0] cal_band_d;
   reg  [1:0] flag_en_q;
   reg  [1:0] flag_en_d;
   reg        therm_q;
   reg        therm_d;
   reg        curr_q;
   reg        curr_d;
   reg        soft_reset_d;
   wire       sel_n;
   wire       soft_hit;
   wire       wr_cal_band;
   wire       wr_flag_en;
   wire       wr_rst_stat;
   wire       therm_clr;
   wire       curr_clr;
   wire [7:0] cal_band_image;
   wire [7:0] flag_en_image;
   wire [7:0] rst_stat_image;

   // One decode serves every register, so no address can be half wired.
   function reg_wr_hit;
      input       stb;
      input [7:0] a;
      input [7:0] target;
      begin
         reg_wr_hit = stb && (a == target);
      end
   endfunction

   // The event is tested first, so a set in the same cycle as a clear wins.
   function flag_next;
      input cur;
      input event_seen;
      input enable;
      input clear;
      begin
         if (event_seen && enable)
            flag_next = 1'b1;
         else if (clear)
            flag_next = 1'b0;
         else
            flag_next = cur;
      end
   endfunction

   // Register select high addresses the converter data path, not these registers.
   assign sel_n = cs_n | reg_select;

   acsr_serial_frame u_frame
   (
      .clock   (clock),
      .rst     (rst),
      .cs_n    (sel_n),
      .sdi     (sdi),
      .rd_data (rd_data),
      .sdo     (sdo),
      .wr_stb  (wr_stb),
      .addr    (addr),
      .wr_data (wr_data)
   );

   assign wr_cal_band = reg_wr_hit(wr_stb, addr, `ACSR_ADDR_CAL_BAND);
   assign wr_flag_en  = reg_wr_hit(wr_stb, addr, `ACSR_ADDR_FLAG_EN);
   assign wr_rst_stat = reg_wr_hit(wr_stb, addr, `ACSR_ADDR_RST_STAT);
   assign soft_hit    = wr_rst_stat &&
      (wr_data[`ACSR_SOFT_MSB:`ACSR_SOFT_LSB] == `ACSR_SOFT_CODE);
   assign therm_clr   = wr_rst_stat && !wr_data[`ACSR_BIT_THERM_FLAG];
   assign curr_clr    = wr_rst_stat && !wr_data[`ACSR_BIT_CURR_FLAG];

   // The first control register is not in the covered set and survives a soft reset.
   always @*
   begin
      cal_band_d = cal_band_q;
      if (wr_cal_band)
         cal_band_d = wr_data[`ACSR_BIT_FILTER_BAND:`ACSR_BIT_TX_CAL];
   end

   always @*
   begin
      flag_en_d = flag_en_q;
      if (soft_hit)
         flag_en_d = FLAG_EN_RST[`ACSR_BIT_CURR_EN:`ACSR_BIT_THERM_EN];
      else if (wr_flag_en)
         flag_en_d = wr_data[`ACSR_BIT_CURR_EN:`ACSR_BIT_THERM_EN];
   end

   always @*
   begin
      therm_d      = flag_next(therm_q, therm_overload, flag_en_q[0], therm_clr);
      curr_d       = flag_next(curr_q, curr_overload, flag_en_q[1], curr_clr);
      soft_reset_d = soft_hit;
   end

   always @(posedge clock)
   begin
      if (rst)
         cal_band_q <= CAL_BAND_RST[`ACSR_BIT_FILTER_BAND:`ACSR_BIT_TX_CAL];
      else
         cal_band_q <= cal_band_d;
   end

   always @(posedge clock)
   begin
      if (rst)
         flag_en_q <= FLAG_EN_RST[`ACSR_BIT_CURR_EN:`ACSR_BIT_THERM_EN];
      else
         flag_en_q <= flag_en_d;
   end

   always @(posedge clock)
   begin
      if (rst)
         therm_q <= RST_STAT_RST[`ACSR_BIT_THERM_FLAG];
      else
         therm_q <= therm_d;
   end

   always @(posedge clock)
   begin
      if (rst)
         curr_q <= RST_STAT_RST[`ACSR_BIT_CURR_FLAG];
      else
         curr_q <= curr_d;
   end

   always @(posedge clock)
   begin
      if (rst)
         soft_reset_pulse <= 1'b0;
      else
         soft_reset_pulse <= soft_reset_d;
   end

   // Reserved and write-only bits are tied here, so they always read their default.
   assign cal_band_image = {rx_ready, CAL_BAND_RST[6:4], cal_band_q};
   assign flag_en_image  = {FLAG_EN_RST[7], flag_en_q, FLAG_EN_RST[4:0]};
   assign rst_stat_image = {RST_STAT_RST[7], curr_q, therm_q, RST_STAT_RST[4:0]};

   always @*
   begin
      case (addr)
         `ACSR_ADDR_CAL_BAND: rd_data = cal_band_image;
         `ACSR_ADDR_FLAG_EN:  rd_data = flag_en_image;
         `ACSR_ADDR_RST_STAT: rd_data = rst_stat_image;
         default:             rd_data = 8'h00;
      endcase
   end

   assign tx_calibration                = cal_band_q[`ACSR_BIT_TX_CAL];
   assign rx_calibration                = cal_band_q[`ACSR_BIT_RX_CAL];
   assign transmit_gain_amp_calibration = cal_band_q[`ACSR_BIT_TX_GAIN_CAL];
   assign filter_band_select            = cal_band_q[`ACSR_BIT_FILTER_BAND];
   assign therm_flag_enable             = flag_en_q[0];
   assign curr_flag_enable              = flag_en_q[1];
   assign therm_flag                    = therm_q;
   assign curr_flag                     = curr_q;
endmodule // acsr_top

// *** acsr_top_sva.sv ***
// Concurrent checks on the overload flags and the soft reset pulse.
`timescale 1ns/1ps
module acsr_chk
(
   input logic clock,
   input logic rst,
   input logic cs_n,
   input logic therm_overload,
   input logic curr_overload,
   input logic therm_flag_enable,
   input logic curr_flag_enable,
   input logic therm_flag,
   input logic curr_flag,
   input logic soft_reset_pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_therm_set: assert property (therm_overload && therm_flag_enable |=> therm_flag)
      else $error("thermal flag missed");
   a_curr_set: assert property (curr_overload && curr_flag_enable |=> curr_flag)
      else $error("current flag missed");
   a_therm_gate: assert property (!therm_flag && !(therm_overload && therm_flag_enable)
      |=> !therm_flag) else $error("thermal flag rose");
   a_curr_gate: assert property (!curr_flag && !(curr_overload && curr_flag_enable)
      |=> !curr_flag) else $error("current flag rose");
   // A clear needs a frame, so with the port quiet for two cycles a flag must hold.
   a_therm_hold: assert property (therm_flag && cs_n && $past(cs_n) |=> therm_flag)
      else $error("thermal flag lost");
   a_curr_hold: assert property (curr_flag && cs_n && $past(cs_n) |=> curr_flag)
      else $error("current flag lost");
   a_pulse_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("pulse too long");
   a_pulse_clear: assert property (soft_reset_pulse |-> ##[0:1] !(therm_flag_enable || curr_flag_enable))
      else $error("enables kept");
   cover property (therm_flag);
   cover property (curr_flag);
   cover property (soft_reset_pulse);
endmodule // acsr_chk
bind acsr_top acsr_chk u_chk (.*);

// *** acsr_host.sv ***
// Host model that sends frames into the serial port.
`timescale 1ns/1ps
module acsr_host
(
   input  logic clock,
   input  logic sdo,
   output logic cs_n,
   output logic sdi,
   output logic reg_select
);
   initial
   begin
      cs_n = 1'b1;
      sdi = 1'b0;
      reg_select = 1'b0;
   end
   // Read data leaves the port one bit per edge from the ninth frame bit on.
   task xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      for (i = 0; i < n; i++)
      begin
         cs_n <= 1'b0;
         sdi <= (i < 16) ? f[15 - i] : !sdi;
         @(posedge clock);
         if (i >= 9 && i <= 16)
            rd = {rd[6:0], sdo};
      end
      cs_n <= 1'b1;
      sdi <= !sdi;
      @(posedge clock);
   endtask
endmodule // acsr_host

// *** acsr_top_tb.sv ***
// Self-checking bench for the control and status slice.
`timescale 1ns/1ps
module acsr_top_tb;
   logic       clock;
   logic       rst;
   logic       rx_ready;
   logic       therm_overload;
   logic       curr_overload;
   wire        cs_n;
   wire        sdi;
   wire        sdo;
   wire        reg_select;
   wire  [3:0] cal;
   wire  [1:0] en;
   wire  [1:0] flg;
   wire        pulse;
   int         fail_count;
   int         compares;
   logic [7:0] rd;
   logic       hit;
   acsr_top DUT (.clock(clock), .rst(rst), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .reg_select(reg_select), .rx_ready(rx_ready), .therm_overload(therm_overload),
      .curr_overload(curr_overload), .tx_calibration(cal[0]), .rx_calibration(cal[1]),
      .transmit_gain_amp_calibration(cal[2]), .filter_band_select(cal[3]),
      .therm_flag_enable(en[0]), .curr_flag_enable(en[1]), .therm_flag(flg[0]),
      .curr_flag(flg[1]), .soft_reset_pulse(pulse));
   acsr_host HOST (.clock(clock), .sdo(sdo), .cs_n(cs_n), .sdi(sdi), .reg_select(reg_select));
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      HOST.xfer({1'b0, a, d}, 16, rd);
   endtask
   task rdc(input logic [6:0] a, input logic [7:0] e);
      HOST.xfer({1'b1, a, 8'h00}, 18, rd);
      check(rd, e, "read");
   endtask
   task bump(input logic t, input logic c);
      therm_overload <= t;
      curr_overload <= c;
      @(posedge clock);
      therm_overload <= 1'b0;
      curr_overload <= 1'b0;
      @(posedge clock);
   endtask
   task t_reset;
      rdc(7'h04, 8'h00);
      rdc(7'h05, 8'h01);
      rdc(7'h09, 8'h00);
   endtask
   task t_control;
      rx_ready <= 1'b1;
      wr(7'h04, 8'hff);
      HOST.xfer({1'b0, 7'h04, 8'h00}, 8, rd);
      rdc(7'h04, 8'h8f);
      check({4'h0, cal}, 8'h0f, "cal");
      wr(7'h04, 8'h0a);
      rx_ready <= 1'b0;
      rdc(7'h04, 8'h0a);
      HOST.reg_select <= 1'b1;
      wr(7'h04, 8'h05);
      HOST.reg_select <= 1'b0;
      rdc(7'h04, 8'h0a);
   endtask
   task t_flags;
      wr(7'h05, 8'hff);
      rdc(7'h05, 8'h61);
      check({6'h00, en}, 8'h03, "enables");
      bump(1'b1, 1'b0);
      rdc(7'h09, 8'h20);
      check({6'h00, flg}, 8'h01, "flags");
      bump(1'b0, 1'b1);
      wr(7'h09, 8'h20);
      rdc(7'h09, 8'h20);
      wr(7'h09, 8'h00);
      wr(7'h05, 8'h20);
      bump(1'b1, 1'b1);
      rdc(7'h09, 8'h20);
      wr(7'h09, 8'h00);
   endtask
   task t_soft;
      wr(7'h05, 8'h60);
      wr(7'h09, 8'h10);
      rdc(7'h05, 8'h61);
      wr(7'h09, 8'h14);
      hit = 1'b0;
      repeat (4)
      begin
         @(posedge clock);
         hit = hit | (pulse === 1'b1);
      end
      check({7'h0, hit}, 8'h01, "pulse");
      rdc(7'h05, 8'h01);
      check({6'h00, en}, 8'h00, "enables");
      rdc(7'h09, 8'h00);
      rdc(7'h04, 8'h0a);
   endtask
   task t_rerst;
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(7'h04, 8'h00);
      check({4'h0, cal}, 8'h00, "cal");
   endtask
   task finish_test;
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      rst = 1'b1;
      rx_ready = 1'b0;
      therm_overload = 1'b0;
      curr_overload = 1'b0;
      fail_count = 0;
      compares = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_control;
      t_flags;
      t_soft;
      t_rerst;
      finish_test;
   end
endmodule // acsr_top_tb
